// File: core/bdw_pkg.sv
package bdw_pkg;

   // Bit timing on the debug wire, in bus clock cycles.
   localparam int BIT_CYC       = 16;
   localparam int SAMPLE_CYC    = 10;
   localparam int ONE_PULSE_CYC = 7;
   localparam int ZERO_LOW_CYC  = 13;
   localparam int PULSE_LEN     = 2;
   localparam int TIMEOUT_CYC   = 512;
   localparam int STEAL_CYC     = 128;

   // Field widths and buffering.
   localparam int CYC_W       = 5;
   localparam int TMO_W       = 10;
   localparam int STEAL_W     = 8;
   localparam int OPC_W       = 8;
   localparam int WORD_W      = 16;
   localparam int FIFO_WIDTH  = 8;
   localparam int FIFO_DEPTH  = 32;

   // Hardware command opcodes.
   localparam logic [7:0] OP_BACKGROUND = 8'h90;
   localparam logic [7:0] OP_RD_BD_BYTE = 8'hE4;
   localparam logic [7:0] OP_RD_BD_WORD = 8'hEC;
   localparam logic [7:0] OP_RD_BYTE    = 8'hE0;
   localparam logic [7:0] OP_RD_WORD    = 8'hE8;
   localparam logic [7:0] OP_WR_BD_BYTE = 8'hC4;
   localparam logic [7:0] OP_WR_BD_WORD = 8'hCC;
   localparam logic [7:0] OP_WR_BYTE    = 8'hC0;
   localparam logic [7:0] OP_WR_WORD    = 8'hC8;

   // Opcode bit positions.
   localparam int OPC_HW_BIT   = 7;
   localparam int OPC_MEM_BIT  = 6;
   localparam int OPC_RD_BIT   = 5;
   localparam int OPC_WORD_BIT = 3;
   localparam int OPC_MAP_BIT  = 2;

   // Debug window addresses and status byte layout.
   localparam logic [15:0] ADDR_STATUS = 16'hFF01;
   localparam logic [15:0] MAP_LO      = 16'hFF00;
   localparam logic [15:0] MAP_HI      = 16'hFFFF;
   localparam logic [15:0] REG_HI      = 16'hFF06;
   localparam logic [15:0] ROM_LO      = 16'hFF20;
   localparam int STATUS_EN_BIT  = 7;
   localparam int STATUS_ACT_BIT = 6;

   typedef enum logic [2:0] {
      PH_OPC,
      PH_ADDR,
      PH_DATA,
      PH_MEM,
      PH_TX,
      PH_FWDATA,
      PH_FWWAIT
   } bdw_phase_t;

endpackage

// File: core/bdw_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module bdw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_in,
   input  wire logic             sys_rst_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   input  wire logic [WIDTH-1:0] wr_data_in,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in,
   output logic      [WIDTH-1:0] rd_data_out
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } bdw_fifo_t;

   bdw_fifo_t q;
   bdw_fifo_t n;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             do_wr;
   logic             do_rd;

   // Full and empty come straight from the fill count.
   assign wr_ready_out = q.cnt != (AW+1)'(DEPTH);
   assign rd_valid_out = q.cnt != '0;
   assign rd_data_out  = mem[q.rp];
   assign do_wr        = wr_valid_in && wr_ready_out;
   assign do_rd        = rd_valid_out && rd_ready_in;

   // Pointers wrap by hand so a depth that is not a power of two works.
   always_comb begin
      n = q;
      if (do_wr) begin
         n.wp = (q.wp == AW'(DEPTH-1)) ? '0 : AW'(q.wp + 1'b1);
      end
      if (do_rd) begin
         n.rp = (q.rp == AW'(DEPTH-1)) ? '0 : AW'(q.rp + 1'b1);
      end
      n.cnt = (AW+1)'(q.cnt + {AW'(0), do_wr} - {AW'(0), do_rd});
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // Storage carries no reset; only the pointers and the fill count need a defined value.
   always_ff @(posedge clk_in) begin
      if (do_wr) begin
         mem[q.wp] <= wr_data_in;
      end
   end
endmodule
`default_nettype wire

// File: core/bdw_port.sv
`timescale 1ns/100ps
`default_nettype none
module bdw_port (
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        debug_wire_pin_in,
   output logic             debug_wire_pin_out,
   output logic             debug_wire_pin_oe_out,
   input  wire logic        special_single_chip_in,
   input  wire logic        tag_hit_in,
   input  wire logic        background_instruction_in,
   input  wire logic        instr_boundary_in,
   input  wire logic        exit_background_in,
   output logic             background_debug_mode_out,
   output logic             firmware_enable_bit_out,
   output logic             activate_refused_out,
   output logic             peripheral_suspend_out,
   input  wire logic [15:0] cpu_addr_in,
   input  wire logic        debug_access_in,
   output logic             debug_reg_sel_out,
   output logic             rom_sel_out,
   input  wire logic        dead_cycle_in,
   output logic             cpu_freeze_out,
   output logic             mem_req_out,
   output logic             mem_we_out,
   output logic             mem_word_out,
   output logic             mem_in_map_out,
   output logic      [15:0] mem_addr_out,
   output logic      [15:0] mem_wdata_out,
   input  wire logic        mem_ack_in,
   input  wire logic [15:0] mem_rdata_in,
   output logic             fw_cmd_valid_out,
   input  wire logic        fw_cmd_ready_in,
   output logic      [7:0]  fw_cmd_data_out,
   input  wire logic        fw_reply_valid_in,
   output logic             fw_reply_ready_out,
   input  wire logic [15:0] fw_reply_data_in
);
   localparam logic [9:0] TMO_MAX  = 10'(bdw_pkg::TIMEOUT_CYC - 1);
   localparam logic [7:0] STEAL_MX = 8'(bdw_pkg::STEAL_CYC - 1);
   localparam logic [4:0] BIT_LAST = 5'(bdw_pkg::BIT_CYC - 1);
   localparam logic [4:0] TX_BITS  = 5'(bdw_pkg::WORD_W);

   typedef struct packed {
      logic                    sync1;
      logic                    sync2;
      logic                    prev;
      logic [4:0]              cyc;
      logic                    in_bit;
      logic [9:0]              tmo;
      bdw_pkg::bdw_phase_t     ph;
      logic [15:0]             sh;
      logic [4:0]              nbits;
      logic [7:0]              opcode;
      logic [15:0]             addr;
      logic [15:0]             wdata;
      logic [15:0]             tx;
      logic [4:0]              tx_left;
      logic                    cur;
      logic                    fw_en;
      logic                    active;
      logic                    bg_pend;
      logic                    boot;
      logic                    req;
      logic                    freeze;
      logic [7:0]              wait_cnt;
      logic                    drv;
      logic                    drv_oe;
      logic                    push;
      logic [7:0]              push_data;
      logic                    refused;
   } bdw_port_t;

   bdw_port_t   q;
   bdw_port_t   n;
   logic        fall;
   logic        sample;
   logic        stall;
   logic        fifo_rdy;
   logic [15:0] new_sh;
   logic        hit_status;

   // Address window test, shared by register and ROM decoding.
   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // The firmware byte path is buffered so firmware may lag the wire.
   bdw_fifo #(
      .WIDTH(bdw_pkg::FIFO_WIDTH),
      .DEPTH(bdw_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_in       (clk_in),
      .sys_rst_in   (sys_rst_in),
      .wr_valid_in  (q.push),
      .wr_ready_out (fifo_rdy),
      .wr_data_in   (q.push_data),
      .rd_valid_out (fw_cmd_valid_out),
      .rd_ready_in  (fw_cmd_ready_in),
      .rd_data_out  (fw_cmd_data_out)
   );

   // A falling edge is seen only on the second stage and its delayed copy.
   assign fall       = q.prev && !q.sync2;
   // A stuck firmware buffer stops bit intake until the byte is taken.
   assign stall      = q.push && !fifo_rdy;
   assign sample     = q.in_bit && (q.cyc == 5'(bdw_pkg::SAMPLE_CYC)) && !stall;
   assign new_sh     = {q.sh[14:0], q.sync2};
   assign hit_status = q.opcode[bdw_pkg::OPC_MAP_BIT] && !q.opcode[bdw_pkg::OPC_WORD_BIT]
                       && (q.addr == bdw_pkg::ADDR_STATUS);

   // Next-state logic for the whole port.
   always_comb begin
      n         = q;
      n.sync1   = debug_wire_pin_in;
      n.sync2   = q.sync1;
      n.prev    = q.sync2;
      n.push    = stall;
      n.refused = 1'b0;
      // Bit-time counter restarts on each host edge; idle counter too.
      if (fall) begin
         n.cyc    = '0;
         n.in_bit = 1'b1;
         n.tmo    = '0;
      end else begin
         if (q.cyc != '1) begin
            n.cyc = 5'(q.cyc + 5'h01);
         end
         if (q.cyc == BIT_LAST) begin
            n.in_bit = 1'b0;
         end
         if (q.tmo != TMO_MAX) begin
            n.tmo = 10'(q.tmo + 10'h001);
         end
      end
      if (sample) begin
         n.sh    = new_sh;
         n.nbits = 5'(q.nbits + 5'h01);
      end
      unique case (q.ph)
         bdw_pkg::PH_OPC: begin
            if (sample && q.nbits == 5'h07) begin
               n.opcode = new_sh[7:0];
               n.nbits  = '0;
               if (new_sh[7:0] == bdw_pkg::OP_BACKGROUND) begin
                  n.bg_pend = q.fw_en;
                  n.refused = !q.fw_en;
               end else if (new_sh[bdw_pkg::OPC_HW_BIT] && new_sh[bdw_pkg::OPC_MEM_BIT]) begin
                  n.ph = bdw_pkg::PH_ADDR;
               end else if (!new_sh[bdw_pkg::OPC_HW_BIT] && new_sh[bdw_pkg::OPC_MEM_BIT]
                            && q.active) begin
                  // Firmware opcodes pass on to the ROM code only in active mode.
                  n.push      = 1'b1;
                  n.push_data = new_sh[7:0];
                  n.ph        = new_sh[bdw_pkg::OPC_RD_BIT] ? bdw_pkg::PH_FWWAIT
                                                            : bdw_pkg::PH_FWDATA;
               end
            end
         end
         bdw_pkg::PH_ADDR: begin
            if (sample && q.nbits == 5'h0F) begin
               n.addr  = new_sh;
               n.nbits = '0;
               n.ph    = q.opcode[bdw_pkg::OPC_RD_BIT] ? bdw_pkg::PH_MEM : bdw_pkg::PH_DATA;
            end
         end
         bdw_pkg::PH_DATA: begin
            if (sample && q.nbits == 5'h0F) begin
               n.wdata = new_sh;
               n.nbits = '0;
               n.ph    = bdw_pkg::PH_MEM;
            end
         end
         bdw_pkg::PH_MEM: begin
            if (hit_status) begin
               // The status byte lives here, so it is served without the bus.
               if (!q.opcode[bdw_pkg::OPC_RD_BIT]) begin
                  n.fw_en = q.wdata[bdw_pkg::STATUS_EN_BIT];
                  n.ph    = bdw_pkg::PH_OPC;
               end else begin
                  n.tx      = '0;
                  n.tx[bdw_pkg::STATUS_EN_BIT]  = q.fw_en;
                  n.tx[bdw_pkg::STATUS_ACT_BIT] = q.active;
                  n.tx_left = TX_BITS;
                  n.ph      = bdw_pkg::PH_TX;
               end
            end else if (mem_ack_in && q.req) begin
               n.req      = 1'b0;
               n.freeze   = 1'b0;
               n.wait_cnt = '0;
               n.tx       = mem_rdata_in;
               n.tx_left  = TX_BITS;
               n.ph       = q.opcode[bdw_pkg::OPC_RD_BIT] ? bdw_pkg::PH_TX : bdw_pkg::PH_OPC;
            end else begin
               // Wait for a dead cycle; after the limit the CPU is frozen.
               n.req = 1'b1;
               if (q.req && q.wait_cnt != STEAL_MX) begin
                  n.wait_cnt = 8'(q.wait_cnt + 8'h01);
               end
               if (q.wait_cnt == STEAL_MX) begin
                  n.freeze = 1'b1;
               end
            end
         end
         bdw_pkg::PH_TX: begin
            if (fall) begin
               n.cur     = q.tx[15];
               n.tx      = {q.tx[14:0], 1'b0};
               n.tx_left = 5'(q.tx_left - 5'h01);
            end else if (q.in_bit && q.cyc == BIT_LAST && q.tx_left == '0) begin
               n.ph    = bdw_pkg::PH_OPC;
               n.nbits = '0;
            end
         end
         bdw_pkg::PH_FWDATA: begin
            if (sample && (q.nbits == 5'h07 || q.nbits == 5'h0F)) begin
               n.push      = 1'b1;
               n.push_data = new_sh[7:0];
               if (q.nbits == 5'h0F) begin
                  n.nbits = '0;
                  n.ph    = bdw_pkg::PH_OPC;
               end
            end
         end
         bdw_pkg::PH_FWWAIT: begin
            if (fw_reply_valid_in) begin
               n.tx      = fw_reply_data_in;
               n.tx_left = TX_BITS;
               n.ph      = bdw_pkg::PH_TX;
            end
         end
         default: begin
            n.ph = bdw_pkg::PH_OPC;
         end
      endcase
      // A silent host aborts any command, but not a pending bus access or firmware reply.
      if (!fall && q.tmo == TMO_MAX && q.ph != bdw_pkg::PH_MEM
          && q.ph != bdw_pkg::PH_FWWAIT) begin
         n.ph     = bdw_pkg::PH_OPC;
         n.nbits  = '0;
         n.opcode = '0;
      end
      // Background entry and exit; an entry request beats an exit.
      if (exit_background_in) begin
         n.active = 1'b0;
      end
      if (tag_hit_in || background_instruction_in) begin
         n.active  = n.active || q.fw_en;
         n.refused = !q.fw_en;
      end
      if (q.bg_pend && instr_boundary_in) begin
         n.active  = 1'b1;
         n.bg_pend = 1'b0;
      end
      // The mode strap is caught on the first edge after reset release.
      if (!q.boot) begin
         n.boot = 1'b1;
         if (special_single_chip_in) begin
            n.fw_en  = 1'b1;
            n.active = 1'b1;
         end
      end
      // Pin drive follows the bit being sent; idle phases never drive.
      n.drv_oe = 1'b0;
      n.drv    = 1'b1;
      if (n.ph == bdw_pkg::PH_TX && n.in_bit && n.tx_left != TX_BITS) begin
         if (n.cur) begin
            n.drv_oe = (n.cyc >= 5'(bdw_pkg::ONE_PULSE_CYC))
                       && (n.cyc < 5'(bdw_pkg::ONE_PULSE_CYC + bdw_pkg::PULSE_LEN));
         end else begin
            n.drv_oe = n.cyc < 5'(bdw_pkg::ZERO_LOW_CYC + bdw_pkg::PULSE_LEN);
            n.drv    = n.cyc >= 5'(bdw_pkg::ZERO_LOW_CYC);
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         q <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, cyc: '1, ph: bdw_pkg::PH_OPC,
                drv: 1'b1, default: '0};
      end else begin
         q <= n;
      end
   end

   // Output drive; high and low are both driven actively when enabled.
   assign debug_wire_pin_out        = q.drv;
   assign debug_wire_pin_oe_out     = q.drv_oe;
   assign background_debug_mode_out = q.active;
   assign firmware_enable_bit_out   = q.fw_en;
   assign activate_refused_out      = q.refused;
   assign peripheral_suspend_out    = q.active;
   assign cpu_freeze_out            = q.freeze;
   assign mem_req_out               = q.req && (dead_cycle_in || q.freeze);
   assign mem_we_out                = !q.opcode[bdw_pkg::OPC_RD_BIT];
   assign mem_word_out              = q.opcode[bdw_pkg::OPC_WORD_BIT];
   assign mem_in_map_out            = q.opcode[bdw_pkg::OPC_MAP_BIT];
   assign mem_addr_out              = q.addr;
   assign mem_wdata_out             = q.wdata;
   assign fw_reply_ready_out        = q.ph == bdw_pkg::PH_FWWAIT;

   // User code never sees the debug registers, even in active mode.
   assign debug_reg_sel_out = q.active && debug_access_in
                              && in_range(cpu_addr_in, bdw_pkg::MAP_LO, bdw_pkg::REG_HI);
   assign rom_sel_out       = q.active
                              && in_range(cpu_addr_in, bdw_pkg::ROM_LO, bdw_pkg::MAP_HI);

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_tx_zero;
      fall && q.ph == bdw_pkg::PH_TX && !q.tx[15];
   endsequence
   sequence s_tx_one;
      fall && q.ph == bdw_pkg::PH_TX && q.tx[15];
   endsequence

   a_zero_held_low: assert property (
      s_tx_zero |=> (debug_wire_pin_oe_out && !debug_wire_pin_out) [*8])
      else $error("Zero bit not held low.");
   a_zero_speedup: assert property (
      s_tx_zero |=> ##13 (debug_wire_pin_oe_out && debug_wire_pin_out))
      else $error("Zero bit speed-up pulse missing at cycle 13.");
   a_one_pulse: assert property (
      s_tx_one |=> !debug_wire_pin_oe_out ##7 (debug_wire_pin_oe_out && debug_wire_pin_out)
      ##2 !debug_wire_pin_oe_out)
      else $error("One bit pulse not at cycles 7 to 8.");
   a_rx_quiet: assert property (
      q.ph inside {bdw_pkg::PH_OPC, bdw_pkg::PH_ADDR, bdw_pkg::PH_DATA}
      |-> !debug_wire_pin_oe_out)
      else $error("Wire driven while host sends.");
   a_msb_first: assert property (
      fall && q.ph == bdw_pkg::PH_TX |=> q.cur == $past(q.tx[15]))
      else $error("Transmit bit not taken from the top.");
   a_sample_ten: assert property (
      q.nbits != $past(q.nbits) && q.nbits != '0
      |-> $past(q.cyc) == 5'(bdw_pkg::SAMPLE_CYC) && $past(q.in_bit))
      else $error("Bit sampled off cycle ten.");
   a_idle_timeout: assert property (
      !fall && q.tmo == TMO_MAX
      && q.ph inside {bdw_pkg::PH_OPC, bdw_pkg::PH_ADDR, bdw_pkg::PH_DATA}
      |=> q.ph == bdw_pkg::PH_OPC && q.opcode == '0)
      else $error("Timeout did not clear the command.");
   a_enable_gate: assert property (
      q.boot && !q.fw_en && !q.bg_pend && !q.active |=> !q.active)
      else $error("Background entered without firmware enable.");
   a_bg_boundary: assert property (
      q.bg_pend && instr_boundary_in |=> q.active && !q.bg_pend)
      else $error("Pending entry missed the boundary.");
   a_steal_cycle: assert property (
      q.req && !mem_ack_in && q.wait_cnt == STEAL_MX |=> cpu_freeze_out && mem_req_out)
      else $error("No cycle stolen after the wait limit.");
   a_reg_private: assert property (
      debug_reg_sel_out |-> debug_access_in && background_debug_mode_out)
      else $error("Debug registers selected for user access.");
   a_boot_special: assert property (
      $rose(q.boot) && $past(special_single_chip_in) |-> q.active && q.fw_en)
      else $error("Special mode not active out of reset.");
endmodule
`default_nettype wire

// File: core/bdw_unused.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// File: test/bdw_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host pod on the debug wire. It only ever pulls the wire low and leaves
// the high level to the pull-up, so it can never fight a device high pulse.
module bdw_host_model (
   input  wire logic clk_in,
   input  wire logic wire_in,
   output logic      pull_low_out
);
   initial pull_low_out = 1'b0;

   // Host-to-device bits; a zero stays low well past the device sample point.
   task automatic tx_bits(input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk_in) pull_low_out <= 1'b1;
         repeat (v[i] ? 2 : 14) @(posedge clk_in);
         pull_low_out <= 1'b0;
         repeat (v[i] ? 18 : 6) @(posedge clk_in);
      end
   endtask

   // Device-to-host bits; the low drive ends long before the speed-up pulse.
   task automatic rx_bits(output logic [15:0] v, input int n);
      v = 16'h0000;
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk_in) pull_low_out <= 1'b1;
         repeat (4) @(posedge clk_in);
         pull_low_out <= 1'b0;
         repeat (6) @(posedge clk_in);
         v[i] = wire_in;
         repeat (10) @(posedge clk_in);
      end
   endtask

   // Opcode, address and data, then the pause for the access to finish.
   task automatic write_cmd(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d);
      tx_bits({8'h00, op}, 8);
      tx_bits(a, 16);
      tx_bits(d, 16);
      repeat (150) @(posedge clk_in);
   endtask

   // Reads pause between the address and the data.
   task automatic read_cmd(input logic [7:0] op, input logic [15:0] a, output logic [15:0] d);
      tx_bits({8'h00, op}, 8);
      tx_bits(a, 16);
      repeat (150) @(posedge clk_in);
      rx_bits(d, 16);
   endtask
endmodule
`default_nettype wire

// File: test/background_debug_single_wire_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module background_debug_single_wire_port_tb;
   logic        clk, rst, pull_low, dout, oe, strap, tag, bgi, bound, ext;
   logic        mode, fw_en, refused, susp, dacc, dsel, rsel, dead, frz;
   logic        mreq, mwe, mword, mmap, mack, fvalid, fready, rvalid, rready;
   logic [15:0] caddr, maddr, mwdata, cap_addr, cap_wdata, d;
   logic [7:0]  fdata;
   logic        pin, cap_we;
   int          checks, fail_count, refused_cnt, frz_cnt;
   // The wire has a pull-up; any party pulling low wins.
   assign pin = ~(pull_low | (oe & ~dout));

   bdw_port DUT (.clk_in(clk), .sys_rst_in(rst), .debug_wire_pin_in(pin),
      .debug_wire_pin_out(dout), .debug_wire_pin_oe_out(oe), .special_single_chip_in(strap),
      .tag_hit_in(tag), .background_instruction_in(bgi), .instr_boundary_in(bound),
      .exit_background_in(ext), .background_debug_mode_out(mode),
      .firmware_enable_bit_out(fw_en), .activate_refused_out(refused),
      .peripheral_suspend_out(susp), .cpu_addr_in(caddr), .debug_access_in(dacc),
      .debug_reg_sel_out(dsel), .rom_sel_out(rsel), .dead_cycle_in(dead),
      .cpu_freeze_out(frz), .mem_req_out(mreq), .mem_we_out(mwe), .mem_word_out(mword),
      .mem_in_map_out(mmap), .mem_addr_out(maddr), .mem_wdata_out(mwdata),
      .mem_ack_in(mack), .mem_rdata_in(16'hA55A), .fw_cmd_valid_out(fvalid),
      .fw_cmd_ready_in(fready), .fw_cmd_data_out(fdata), .fw_reply_valid_in(rvalid),
      .fw_reply_ready_out(rready), .fw_reply_data_in(16'h1357));
   bdw_host_model HOST (.clk_in(clk), .wire_in(pin), .pull_low_out(pull_low));

   // Memory and firmware responders, plus counters of refusal pulses and freeze cycles.
   // Scenarios compare against a snapshot, so nothing else writes these.
   always @(posedge clk) begin
      if (rst) begin
         mack <= 1'b0;
         rvalid <= 1'b0;
         refused_cnt <= 0;
         frz_cnt <= 0;
      end else begin
         mack <= mreq & ~mack;
         rvalid <= rready;
         refused_cnt <= refused_cnt + int'(refused);
         frz_cnt <= frz_cnt + int'(frz);
      end
      if (mreq) begin
         cap_addr <= maddr;
         cap_wdata <= mwdata;
         cap_we <= mwe;
      end
   end

   // One-cycle strobe: 0 boundary, 1 tag, 2 instruction, 3 exit.
   task automatic pulse(input int sel);
      @(posedge clk) begin
         bound <= (sel == 0);
         tag <= (sel == 1);
         bgi <= (sel == 2);
         ext <= (sel == 3);
      end
      @(posedge clk) {bound, tag, bgi, ext} <= 4'h0;
      repeat (3) @(posedge clk);
   endtask

   // Both the command and a tag are refused while firmware is disabled.
   task automatic sc_refused;
      int base;
      HOST.read_cmd(8'hE4, 16'hFF01, d);
      `CHK(d, 16'h0000)
      base = refused_cnt;
      HOST.tx_bits(16'h0090, 8);
      repeat (150) @(posedge clk);
      pulse(1);
      `CHK(refused_cnt - base, 2)
      `CHK(mode, 1'b0)
   endtask

   task automatic sc_enable;
      HOST.write_cmd(8'hC4, 16'hFF01, 16'h0080);
      `CHK(fw_en, 1'b1)
      HOST.read_cmd(8'hE4, 16'hFF01, d);
      `CHK(d, 16'h0080)
   endtask

   // Busy bus forces a freeze; a free bus does not.
   task automatic sc_memory;
      int base;
      base = frz_cnt;
      HOST.read_cmd(8'hE8, 16'h1234, d);
      `CHK(d, 16'hA55A)
      `CHK(cap_addr, 16'h1234)
      `CHK(frz_cnt == base, 1'b0)
      `CHK({mword, mmap}, 2'b10)
      @(posedge clk) dead <= 1'b1;
      base = frz_cnt;
      HOST.write_cmd(8'hC8, 16'h2468, 16'hBEEF);
      `CHK(cap_wdata, 16'hBEEF)
      `CHK(cap_we, 1'b1)
      `CHK(frz_cnt == base, 1'b1)
      @(posedge clk) dead <= 1'b0;
   endtask

   task automatic sc_background;
      HOST.tx_bits(16'h0090, 8);
      repeat (30) @(posedge clk);
      `CHK(mode, 1'b0)
      pulse(0);
      `CHK(mode, 1'b1)
      `CHK(susp, 1'b1)
      HOST.read_cmd(8'hE4, 16'hFF01, d);
      `CHK(d, 16'h00C0)
      @(posedge clk) caddr <= 16'hFF20;
      @(posedge clk) #1 `CHK(rsel, 1'b1)
      @(posedge clk) caddr <= 16'hFF06;
      dacc <= 1'b1;
      @(posedge clk) #1 `CHK(dsel, 1'b1)
      @(posedge clk) dacc <= 1'b0;
      @(posedge clk) #1 `CHK(dsel, 1'b0)
   endtask

   // Firmware stream stalls in the FIFO until the bench drains it.
   task automatic sc_firmware;
      logic [7:0] exp [3] = '{8'h44, 8'hBE, 8'hEF};
      HOST.tx_bits(16'h0044, 8);
      HOST.tx_bits(16'hBEEF, 16);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk) #1 `CHK(fvalid, 1'b1)
         `CHK(fdata, exp[i])
         @(posedge clk) fready <= 1'b1;
         @(posedge clk) fready <= 1'b0;
      end
      HOST.tx_bits(16'h0064, 8);
      repeat (150) @(posedge clk);
      HOST.rx_bits(d, 16);
      `CHK(d, 16'h1357)
      `CHK(fvalid, 1'b1)
      `CHK(fdata, 8'h64)
      @(posedge clk) fready <= 1'b1;
      @(posedge clk) fready <= 1'b0;
      pulse(3);
      `CHK(mode, 1'b0)
      `CHK(susp, 1'b0)
      HOST.tx_bits(16'h0044, 8);
      repeat (20) @(posedge clk);
      `CHK(fvalid, 1'b0)
      pulse(1);
      `CHK(mode, 1'b1)
      pulse(3);
      pulse(2);
      `CHK(mode, 1'b1)
      pulse(3);
   endtask

   task automatic sc_timeout;
      HOST.tx_bits(16'h000E, 4);
      repeat (600) @(posedge clk);
      HOST.read_cmd(8'hE4, 16'hFF01, d);
      `CHK(d, 16'h0080)
      @(posedge clk) strap <= 1'b1;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(mode, 1'b1)
      `CHK(fw_en, 1'b1)
   endtask

   task automatic print_verdict;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Reset, then the scenarios in an order that builds up enable and mode.
   initial begin
      {rst, strap, tag, bgi, bound, ext, dacc, dead, fready} = 9'h100;
      caddr = 16'h0000;
      checks = 0;
      fail_count = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      sc_refused();
      sc_enable();
      sc_memory();
      sc_background();
      sc_firmware();
      sc_timeout();
      print_verdict();
   end

   // The whole run needs about 10000 cycles; this cuts a hang short.
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
